// ==== include/hspm_consts.svh ====
// offsets, field positions, values and timing counts of the hot-plug bridge registers
`ifndef HSPM_CONSTS_SVH
`define HSPM_CONSTS_SVH

`define HSPM_ADDR_W 8
`define HSPM_DATA_W 8

`define HSPM_OFS_BRIDGE_EXT 8'hE2
`define HSPM_OFS_DATA 8'hE3
`define HSPM_OFS_CAP_ID 8'hE4
`define HSPM_OFS_NEXT_PTR 8'hE5
`define HSPM_OFS_CTRL_STATUS 8'hE6
`define HSPM_OFS_IRQ_STATUS 8'hE8
`define HSPM_OFS_IRQ_MASK 8'hE9

`define HSPM_DATA_VAL 8'h00
`define HSPM_CAP_ID_VAL 8'h06
`define HSPM_NEXT_PTR_VAL 8'h00
`define HSPM_CSR_RST 8'h00
`define HSPM_ZERO 8'h00

`define HSPM_EXT_BCC_BIT 7
`define HSPM_EXT_B23_BIT 6
`define HSPM_CSR_INS_BIT 7
`define HSPM_CSR_EXT_BIT 6
`define HSPM_CSR_LED_BIT 3
`define HSPM_CSR_MASK_BIT 1

`define HSPM_IRQ_INS_BIT 0
`define HSPM_IRQ_EXT_BIT 1
`define HSPM_IRQ_W 2

`define HSPM_SEC_CLK_DIV 2

`endif

// ==== include/hspm_pkg.sv ====
// types shared by the hot-plug bridge register block
package hspm_pkg;
    typedef enum logic [1:0] {
        PS_D0,
        PS_D1,
        PS_D2,
        PS_D3HOT
    } hspm_pstate_t;

    typedef enum logic {
        LED_FORCED,
        LED_SOFT
    } hspm_led_t;
endpackage : hspm_pkg

// ==== verilog/hspm_sync.sv ====
// two-stage synchroniser for pin levels
`timescale 1ns/10ps
module hspm_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("hspm_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule : hspm_sync

// ==== verilog/hspm_sec_clk.sv ====
// secondary clock divider with D3hot stop
`timescale 1ns/10ps
`include "hspm_consts.svh"
module hspm_sec_clk #(
    parameter int DIV = `HSPM_SEC_CLK_DIV
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stop_in_d3,
    input wire hspm_pkg::hspm_pstate_t power_state,
    output logic sec_clk_out
);
    localparam int CW = (DIV > 2) ? $clog2(DIV / 2) : 1;
    localparam logic [CW-1:0] HALF_M1 = CW'(DIV / 2 - 1);
    logic [CW-1:0] cnt_q;
    logic run;

    if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
        $error("hspm_sec_clk: DIV must be even and at least 2");
    end

    assign run = !(stop_in_d3 && power_state == hspm_pkg::PS_D3HOT);

    // built from primary clock
    // no edge of clk means no edge out, so a stopped primary stops it too
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
            sec_clk_out <= 1'b0;
        end else if (!run) begin
            cnt_q <= '0;
            sec_clk_out <= 1'b0;
        end else if (cnt_q == HALF_M1) begin
            cnt_q <= '0;
            sec_clk_out <= !sec_clk_out;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    sec_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        !run |=> !sec_clk_out)
        else $error("secondary clock runs in D3hot with stop enabled");

    sec_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
        run && cnt_q == HALF_M1 && $past(run) |=> sec_clk_out != $past(sec_clk_out))
        else $error("secondary clock missed its toggle");
endmodule : hspm_sec_clk

// ==== verilog/hspm_bridge_regs.sv ====
// hot-plug and power management bridge extension registers
`timescale 1ns/10ps
`include "hspm_consts.svh"
module hspm_bridge_regs #(
    parameter int SEC_CLK_DIV = `HSPM_SEC_CLK_DIV
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`HSPM_ADDR_W-1:0] reg_addr,
    input wire logic [`HSPM_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`HSPM_DATA_W-1:0] reg_rdata,
    input wire logic bus_clock_ctrl_strap,
    input wire logic ejector_closed,
    input wire hspm_pkg::hspm_pstate_t pm_control_status,
    output logic enum_output_pin,
    output logic hot_plug_led,
    output logic sec_clk_out,
    output logic irq
);
    localparam int DW = `HSPM_DATA_W;

    // synchronised pin levels
    logic strap_s;
    logic closed_s;
    logic closed_prev_q;

    // control/status state
    logic ins_q;
    logic ext_q;
    logic led_bit_q;
    logic mask_q;
    logic reset_seen_q;
    hspm_pkg::hspm_led_t led_st_q;

    // interrupt state
    logic [`HSPM_IRQ_W-1:0] irq_stat_q;
    logic [`HSPM_IRQ_W-1:0] irq_mask_q;

    // decoded accesses and events
    logic csr_wr;
    logic irq_stat_rd;
    logic ins_set;
    logic ext_set;
    logic open_edge;
    logic ins_clr;
    logic ext_clr;

    if (SEC_CLK_DIV < 2) begin : g_bad_div
        $error("hspm_bridge_regs: SEC_CLK_DIV must be at least 2");
    end

    // read value of one offset; unmapped offsets read zero
    function automatic logic [DW-1:0] read_value(
        input logic [`HSPM_ADDR_W-1:0] addr
    );
        logic [DW-1:0] v;
        v = `HSPM_ZERO;
        case (addr)
            // strap level on bits 7 and 6
            `HSPM_OFS_BRIDGE_EXT: begin
                v[`HSPM_EXT_BCC_BIT] = strap_s;
                v[`HSPM_EXT_B23_BIT] = strap_s;
            end
            `HSPM_OFS_DATA: v = `HSPM_DATA_VAL;
            `HSPM_OFS_CAP_ID: v = `HSPM_CAP_ID_VAL;
            `HSPM_OFS_NEXT_PTR: v = `HSPM_NEXT_PTR_VAL;
            // writable bits read back beside the flags
            `HSPM_OFS_CTRL_STATUS: begin
                v[`HSPM_CSR_INS_BIT] = ins_q;
                v[`HSPM_CSR_EXT_BIT] = ext_q;
                v[`HSPM_CSR_LED_BIT] = led_bit_q;
                v[`HSPM_CSR_MASK_BIT] = mask_q;
            end
            `HSPM_OFS_IRQ_STATUS: v[`HSPM_IRQ_W-1:0] = irq_stat_q;
            `HSPM_OFS_IRQ_MASK: v[`HSPM_IRQ_W-1:0] = irq_mask_q;
            default: v = `HSPM_ZERO;
        endcase
        return v;
    endfunction : read_value

    // strap and ejector switch come from pins
    hspm_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({bus_clock_ctrl_strap, ejector_closed}),
        .sync_out({strap_s, closed_s})
    );

    // secondary clock generation
    hspm_sec_clk #(
        .DIV(SEC_CLK_DIV)
    ) u_sec_clk (
        .clk(clk),
        .sys_rst(sys_rst),
        .stop_in_d3(strap_s),
        .power_state(pm_control_status),
        .sec_clk_out(sec_clk_out)
    );

    // access decode
    assign csr_wr = reg_wr && reg_addr == `HSPM_OFS_CTRL_STATUS;
    assign irq_stat_rd = reg_rd && reg_addr == `HSPM_OFS_IRQ_STATUS;

    assign ins_set = reset_seen_q && closed_s && !ext_q;
    assign open_edge = closed_prev_q && !closed_s;
    assign ext_set = open_edge && !ins_q;

    assign ins_clr = csr_wr && reg_wdata[`HSPM_CSR_INS_BIT];
    assign ext_clr = csr_wr && reg_wdata[`HSPM_CSR_EXT_BIT];

    // edge history of the switch; reset value avoids a false open edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            closed_prev_q <= 1'b0;
        end else begin
            closed_prev_q <= closed_s;
        end
    end

    // bus reset marker, consumed by the first insertion
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_seen_q <= 1'b1;
        end else if (ins_set) begin
            reset_seen_q <= 1'b0;
        end
    end

    // mask has no say here
    // set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ins_q <= 1'b0;
        end else if (ins_set) begin
            ins_q <= 1'b1;
        end else if (ins_clr) begin
            ins_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_q <= 1'b0;
        end else if (ext_set) begin
            ext_q <= 1'b1;
        end else if (ext_clr) begin
            ext_q <= 1'b0;
        end
    end

    // writable control bits reset to zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            led_bit_q <= 1'b0;
            mask_q <= 1'b0;
        end else if (csr_wr) begin
            led_bit_q <= reg_wdata[`HSPM_CSR_LED_BIT];
            mask_q <= reg_wdata[`HSPM_CSR_MASK_BIT];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            led_st_q <= hspm_pkg::LED_FORCED;
        end else begin
            case (led_st_q)
                hspm_pkg::LED_FORCED: begin
                    if (closed_s) begin
                        led_st_q <= hspm_pkg::LED_SOFT;
                    end
                end
                hspm_pkg::LED_SOFT: led_st_q <= hspm_pkg::LED_SOFT;
                default: led_st_q <= hspm_pkg::LED_FORCED;
            endcase
        end
    end

    // LED level from the control bit once released
    // lit at reset so a board in a half-seated state shows it is unsafe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hot_plug_led <= 1'b1;
        end else if (led_st_q == hspm_pkg::LED_FORCED) begin
            hot_plug_led <= 1'b1;
        end else begin
            hot_plug_led <= led_bit_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enum_output_pin <= 1'b0;
        end else begin
            enum_output_pin <= (ins_q || ext_q) && !mask_q;
        end
    end

    // sticky interrupt bits; read clears, a new event in that cycle survives
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q[`HSPM_IRQ_INS_BIT] <= (ins_set && !ins_q) ||
                (irq_stat_q[`HSPM_IRQ_INS_BIT] && !irq_stat_rd);
            irq_stat_q[`HSPM_IRQ_EXT_BIT] <= (ext_set && !ext_q) ||
                (irq_stat_q[`HSPM_IRQ_EXT_BIT] && !irq_stat_rd);
        end
    end

    // interrupt mask, 1 enables the matching status bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask_q <= '0;
        end else if (reg_wr && reg_addr == `HSPM_OFS_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[`HSPM_IRQ_W-1:0];
        end
    end

    // level interrupt
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read data stand one cycle after the strobe, then fall to zero
    // zero between reads so a stale value is never taken for an answer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `HSPM_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= read_value(reg_addr);
        end else begin
            reg_rdata <= `HSPM_ZERO;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    strap_bit7_a: assert property (
        reg_rd && reg_addr == `HSPM_OFS_BRIDGE_EXT |=> reg_rdata[7] == $past(strap_s))
        else $error("extension bit 7 differs from strap");

    strap_bit6_a: assert property (
        reg_rd && reg_addr == `HSPM_OFS_BRIDGE_EXT |=> reg_rdata[6] == reg_rdata[7])
        else $error("extension bit 6 differs from bit 7");

    ext_reserved_a: assert property (
        reg_rd && reg_addr == `HSPM_OFS_BRIDGE_EXT |=> reg_rdata[5:0] == 6'h00)
        else $error("extension reserved bits not zero");

    data_reg_a: assert property (
        reg_rd && reg_addr == `HSPM_OFS_DATA |=> reg_rdata == 8'h00)
        else $error("data register not zero");

    cap_id_a: assert property (
        reg_rd && reg_addr == `HSPM_OFS_CAP_ID |=> reg_rdata == 8'h06)
        else $error("capability id wrong");

    next_ptr_a: assert property (
        reg_rd && reg_addr == `HSPM_OFS_NEXT_PTR |=> reg_rdata == 8'h00)
        else $error("next pointer not zero");

    insert_set_a: assert property (
        reset_seen_q && closed_s && !ext_q |=> ins_q && !reset_seen_q)
        else $error("insertion flag not set");

    extract_set_a: assert property (
        closed_prev_q && !closed_s && !ins_q |=> ext_q)
        else $error("extraction flag not set on handle open");

    enum_drive_a: assert property (
        (ins_q || ext_q) && !mask_q |=> enum_output_pin)
        else $error("enumeration output not driven");

    hw_only_set_a: assert property (
        $rose(ins_q) |-> $past(ins_set))
        else $error("insertion flag set without hardware cause");

    w1c_clear_a: assert property (
        ins_q && csr_wr && reg_wdata[7] && !ins_set |=> !ins_q)
        else $error("write one did not clear insertion flag");

    led_soft_a: assert property (
        led_st_q == hspm_pkg::LED_SOFT |=> hot_plug_led == $past(led_bit_q))
        else $error("LED does not follow control bit");

    led_forced_a: assert property (
        led_st_q == hspm_pkg::LED_FORCED |=> hot_plug_led)
        else $error("LED not forced high after reset");

    enum_mask_a: assert property (
        mask_q |=> !enum_output_pin)
        else $error("masked enumeration output asserted");

    mask_indep_a: assert property (
        ext_set && mask_q |=> ext_q)
        else $error("extraction flag blocked by mask");

    csr_reserved_a: assert property (
        reg_rd && reg_addr == `HSPM_OFS_CTRL_STATUS |=>
            reg_rdata[5:4] == 2'h0 && reg_rdata[2] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("control/status reserved bits not zero");

    irq_level_a: assert property (
        |(irq_stat_q & irq_mask_q) |=> irq)
        else $error("interrupt output missing");

    ext_hw_only_a: assert property (
        $rose(ext_q) |-> $past(ext_set))
        else $error("extraction flag set without hardware cause");

    ext_w1c_a: assert property (
        ext_q && ext_clr && !ext_set |=> !ext_q)
        else $error("write one did not clear extraction flag");

    w0_keep_a: assert property (
        ins_q && csr_wr && !reg_wdata[`HSPM_CSR_INS_BIT] |=> ins_q)
        else $error("write zero cleared insertion flag");

    irq_rd_clr_a: assert property (
        irq_stat_rd && !ins_set && !ext_set |=> irq_stat_q == '0)
        else $error("interrupt status not cleared by read");
endmodule : hspm_bridge_regs

// ==== test/hspm_board_model.sv ====
// board-side model: ejector handle switch and bus clock control strap
`timescale 1ns/10ps
module hspm_board_model (
    input wire logic clk,
    input wire logic handle_cmd,
    input wire logic strap_cmd,
    output logic ejector_closed,
    output logic bus_clock_ctrl_strap
);
    // handle contacts move
    // unknown only until the first edge, which falls inside reset
    // contacts change only after an edge; the block must synchronise them anyway
    always @(posedge clk) begin
        ejector_closed <= handle_cmd;
        bus_clock_ctrl_strap <= strap_cmd;
    end
endmodule : hspm_board_model

// ==== test/tb_hspm_bridge_regs.sv ====
// self-checking bench for the hot-plug bridge register block
`timescale 1ns/10ps
`include "hspm_consts.svh"
module tb_hspm_bridge_regs;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic handle_cmd = 1'b0;
    logic strap_cmd = 1'b0;
    logic bus_clock_ctrl_strap;
    logic ejector_closed;
    hspm_pkg::hspm_pstate_t pm_state = hspm_pkg::PS_D0;
    logic enum_output_pin;
    logic hot_plug_led;
    logic sec_clk_out;
    logic irq;
    int error_cnt = 0;
    int check_count = 0;

    hspm_bridge_regs uut (
        .clk(clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .bus_clock_ctrl_strap(bus_clock_ctrl_strap),
        .ejector_closed(ejector_closed),
        .pm_control_status(pm_state),
        .enum_output_pin(enum_output_pin),
        .hot_plug_led(hot_plug_led),
        .sec_clk_out(sec_clk_out),
        .irq(irq)
    );

    hspm_board_model board (
        .clk(clk),
        .handle_cmd(handle_cmd),
        .strap_cmd(strap_cmd),
        .ejector_closed(ejector_closed),
        .bus_clock_ctrl_strap(bus_clock_ctrl_strap)
    );

    // 20 MHz primary clock
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic fail(input string msg);
        error_cnt++;
        $display("ERROR at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail($sformatf("%s got %h expected %h", what, got, exp));
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail($sformatf("%s got %b expected %b", what, got, exp));
        end
    endtask : chk1

    // one-cycle write strobe; a gap edge follows before the next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp, $sformatf("read %h", a));
    endtask : rd_chk

    // bounded wait on the enumeration level; running out ends the run
    task automatic wait_enum(input logic exp);
        int n;
        n = 0;
        while (enum_output_pin !== exp && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_count++;
        if (n == 20) begin
            fail("enum level never reached");
            report_and_stop();
        end
    endtask : wait_enum

    // settle past the strap synchroniser, then look for any toggle in 8 cycles
    task automatic clk_runs(input logic exp);
        logic seen;
        logic last;
        seen = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        last = sec_clk_out;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (sec_clk_out !== last) begin
                seen = 1'b1;
            end
            last = sec_clk_out;
        end
        chk1(seen, exp, "secondary clock activity");
    endtask : clk_runs

    // main sequence, starting with the handle open
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk1(hot_plug_led, 1'b1, "led after reset");
        chk1(enum_output_pin, 1'b0, "enum after reset");
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h00);
        // fixed registers ignore writes
        wr(`HSPM_OFS_CAP_ID, 8'hFF);
        wr(`HSPM_OFS_BRIDGE_EXT, 8'hFF);
        rd_chk(`HSPM_OFS_BRIDGE_EXT, 8'h00);
        rd_chk(`HSPM_OFS_DATA, 8'h00);
        rd_chk(`HSPM_OFS_CAP_ID, 8'h06);
        rd_chk(`HSPM_OFS_NEXT_PTR, 8'h00);
        rd_chk(8'h10, 8'h00);
        // every power state keeps clocks running with the strap low
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            pm_state <= hspm_pkg::hspm_pstate_t'(s);
            clk_runs(1'b1);
        end
        @(posedge clk);
        strap_cmd <= 1'b1;
        clk_runs(1'b0);
        rd_chk(`HSPM_OFS_BRIDGE_EXT, 8'hC0);
        // with the strap high only D3hot stops them
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            pm_state <= hspm_pkg::hspm_pstate_t'(s);
            clk_runs(1'b1);
        end
        @(posedge clk);
        strap_cmd <= 1'b0;
        // software writes cannot set flags; led stays forced
        wr(`HSPM_OFS_IRQ_MASK, 8'h03);
        wr(`HSPM_OFS_CTRL_STATUS, 8'hFF);
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h0A);
        chk1(hot_plug_led, 1'b1, "led forced");
        chk1(enum_output_pin, 1'b0, "enum without flags");
        wr(`HSPM_OFS_CTRL_STATUS, 8'h00);
        // insertion
        @(posedge clk);
        handle_cmd <= 1'b1;
        wait_enum(1'b1);
        @(posedge clk);
        #1;
        chk1(hot_plug_led, 1'b0, "led follows bit 3");
        chk1(irq, 1'b1, "irq on insertion");
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h80);
        rd_chk(`HSPM_OFS_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk1(irq, 1'b0, "irq after status read");
        wr(`HSPM_OFS_CTRL_STATUS, 8'h08);
        repeat (2) @(posedge clk);
        #1;
        chk1(hot_plug_led, 1'b1, "led on by software");
        // mask hides the flag, then write 1 clears it for good
        wr(`HSPM_OFS_CTRL_STATUS, 8'h0A);
        wait_enum(1'b0);
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h8A);
        wr(`HSPM_OFS_CTRL_STATUS, 8'h88);
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h08);
        chk1(enum_output_pin, 1'b0, "enum after clear");
        // extraction under mask with its interrupt disabled
        wr(`HSPM_OFS_IRQ_MASK, 8'h01);
        wr(`HSPM_OFS_CTRL_STATUS, 8'h0A);
        @(posedge clk);
        handle_cmd <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk1(enum_output_pin, 1'b0, "enum masked");
        chk1(irq, 1'b0, "masked extraction irq");
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h4A);
        rd_chk(`HSPM_OFS_IRQ_STATUS, 8'h02);
        wr(`HSPM_OFS_CTRL_STATUS, 8'h08);
        wait_enum(1'b1);
        wr(`HSPM_OFS_CTRL_STATUS, 8'h48);
        wait_enum(1'b0);
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h08);
        // closing again without a bus reset must not insert
        @(posedge clk);
        handle_cmd <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk1(enum_output_pin, 1'b0, "no insertion without reset");
        // second bus reset with the handle closed re-arms insertion
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk1(hot_plug_led, 1'b1, "led forced after second reset");
        wait_enum(1'b1);
        @(posedge clk);
        #1;
        chk1(hot_plug_led, 1'b0, "led bit reset to zero");
        chk1(irq, 1'b0, "irq mask reset");
        rd_chk(`HSPM_OFS_CTRL_STATUS, 8'h80);
        rd_chk(`HSPM_OFS_IRQ_STATUS, 8'h01);
        report_and_stop();
    end
endmodule : tb_hspm_bridge_regs
